// ==== rtl/crs_addr_form.sv ====
// Purpose: Forms a 32-bit pointer and a physical address from selector and offset.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Protected mode takes the segment base from an outside translation stage.
`timescale 1ns/1ps
`default_nettype none
`include "crs_params.svh"

module crs_addr_form (
   input wire logic [15:0] selector_i,
   input wire logic [15:0] offset_i,
   input wire logic prot_mode_i,
   input wire logic [23:0] xlat_base_i,
   output logic [31:0] ptr_o,
   output logic [23:0] phys_o
);
   import crs_pkg::*;

   // -------------------------------------------------------------------------
   // Address forming
   // -------------------------------------------------------------------------
   logic [23:0] real_base;
   logic [23:0] off_ext;

   // Selector is the upper half of the pointer, offset the lower half.
   assign ptr_o = {selector_i, offset_i};
   // Real mode reads the selector as a paragraph address of the segment.
   assign real_base = {4'h0, selector_i, 4'h0};
   assign off_ext = {8'h00, offset_i};
   // Protected mode adds the offset to the translated segment base.
   assign phys_o = prot_mode_i ? (xlat_base_i + off_ext) : (real_base + off_ext);

endmodule : crs_addr_form
`default_nettype wire

// ==== rtl/crs_params.svh ====
// Purpose: Constants for the processor application register set.
// Assumes: Included by the package user files by bare name.
// Notes:   Definitions only; the guard stops double inclusion.
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------------
`define CRS_WORD_W 16
`define CRS_PHYS_W 24
`define CRS_LO_MSB 7
`define CRS_HI_LSB 8
`define CRS_HI_MSB 15

// ----------------------------------------------------------------------------
// General register indices (byte aliases use index bit 2 for the high half)
// ----------------------------------------------------------------------------
`define CRS_GPR_ACCUMULATOR 3'h0
`define CRS_GPR_COUNT 3'h1
`define CRS_GPR_DATA 3'h2
`define CRS_GPR_BASE 3'h3
`define CRS_GPR_STACK_TOP 3'h4
`define CRS_GPR_FRAME_BASE 3'h5
`define CRS_GPR_SRC_INDEX 3'h6
`define CRS_GPR_DEST_INDEX 3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CRS_GPR_RST 16'h0000
`define CRS_SEG_RST 16'h0000
`define CRS_CODE_SEL_RST 16'h0000
`define CRS_INSTR_PTR_RST 16'h0000

`endif

// ==== rtl/crs_pkg.sv ====
// Purpose: Types shared by the application register set files.
// Assumes: crs_params.svh is on the include path.
// Notes:   Segment kind codes follow enum order.
package crs_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   // Kind of segment selector register.
   typedef enum logic [1:0] {
      CRS_SEG_EXTRA,
      CRS_SEG_CODE,
      CRS_SEG_STACK,
      CRS_SEG_DATA
   } crs_seg_type;

   // One 16-bit word.
   typedef logic [15:0] crs_word_type;

   // Complete state of the register set.
   typedef struct packed {
      logic [7:0][15:0] gpr;
      logic [3:0][15:0] seg;
      logic [15:0] instruction_pointer;
      logic [15:0] rd_a;
      logic [15:0] rd_b;
      logic [31:0] fetch_ptr;
      logic [23:0] fetch_phys;
      logic [31:0] ea_ptr;
      logic [23:0] ea_phys;
      logic ea_valid;
      logic seg_refused;
   } crs_state_type;

endpackage : crs_pkg

// ==== rtl/crs_reg_set.sv ====
// Purpose: Application register set: general registers, selectors, fetch and
//          operand address forming for the execution unit.
// Assumes: All inputs are synchronous to sys_clk_i; one write per port per cycle.
// Notes:   Reads are registered and see the value before a same-cycle write.
//
// Notes on behaviour
// - Eight general registers, sixteen bits each, hold arithmetic and logic operands.
// - Any general register can be a source or destination operand.
// - Four general registers each have a high and a low byte alias.
// - Those four registers are reachable as a word or as two bytes.
// - Stack top and frame base registers hold stack offsets.
// - Four selector registers: code, stack, data and extra segments.
// - The full 16-bit selector value names the current segment.
// - Pointer is selector in the upper half, offset in the lower half.
// - Elements in a segment are addressed by a 16-bit offset from its base.
// - Fetch uses code selector and instruction pointer as a 32-bit pointer.
// - Code selector changes only by control transfer, interrupt or trap.
// - Stack accesses use the stack selector, usually with stack or frame offsets.
// - Stack selector can be loaded by explicit load instructions.
// - Data and extra selectors can be loaded at any time.
// - Data offsets come from a displacement and/or base and index registers.
// - In real mode the selector directly gives the segment's physical address.
// - In protected mode a translation stage maps logical to physical addresses.
`timescale 1ns/1ps
`default_nettype none
`include "crs_params.svh"

module crs_reg_set (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [2:0] rd_a_sel_i,
   input wire logic rd_a_byte_i,
   input wire logic [2:0] rd_b_sel_i,
   input wire logic rd_b_byte_i,
   output logic [15:0] rd_a_data_o,
   output logic [15:0] rd_b_data_o,
   input wire logic wr_en_i,
   input wire logic wr_byte_i,
   input wire logic [2:0] wr_sel_i,
   input wire logic [15:0] wr_data_i,
   input wire logic seg_wr_en_i,
   input wire crs_pkg::crs_seg_type seg_wr_sel_i,
   input wire logic seg_wr_xfer_i,
   input wire logic [15:0] seg_wr_data_i,
   output logic seg_refused_o,
   input wire logic instruction_pointer_load_i,
   input wire logic [15:0] instruction_pointer_data_i,
   input wire logic instruction_pointer_adv_i,
   input wire logic [3:0] instruction_pointer_len_i,
   input wire logic prot_mode_i,
   input wire logic [23:0] code_xlat_base_i,
   input wire logic [23:0] oper_xlat_base_i,
   output logic [31:0] fetch_ptr_o,
   output logic [23:0] fetch_phys_o,
   input wire logic ea_req_i,
   input wire logic ea_stack_i,
   input wire crs_pkg::crs_seg_type ea_seg_i,
   input wire logic ea_base_en_i,
   input wire logic [2:0] ea_base_sel_i,
   input wire logic ea_index_en_i,
   input wire logic [2:0] ea_index_sel_i,
   input wire logic [15:0] ea_disp_i,
   output logic [31:0] ea_ptr_o,
   output logic [23:0] ea_phys_o,
   output logic ea_valid_o
);
   import crs_pkg::*;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // Reads a register as a word, or as a byte alias zero-extended.
   // Byte index 0..3 is a low byte, 4..7 the high byte of register index[1:0].
   function automatic crs_word_type crs_read(input logic [7:0][15:0] regs,
                                             input logic [2:0] idx,
                                             input logic as_byte);
      crs_word_type w;
      w = regs[{1'b0, idx[1:0]}];
      if (!as_byte) begin
         crs_read = regs[idx];
      end else if (idx[2]) begin
         crs_read = {8'h00, w[`CRS_HI_MSB:`CRS_HI_LSB]};
      end else begin
         crs_read = {8'h00, w[`CRS_LO_MSB:0]};
      end
   endfunction : crs_read

   // -------------------------------------------------------------------------
   // State and address forming
   // -------------------------------------------------------------------------
   crs_state_type st_q;
   crs_state_type st_d;
   logic [15:0] code_sel;
   logic [15:0] oper_sel;
   logic [15:0] oper_off;
   logic [31:0] fetch_ptr;
   logic [23:0] fetch_phys;
   logic [31:0] ea_ptr;
   logic [23:0] ea_phys;

   // Code selector and instruction pointer always form the fetch address.
   assign code_sel = st_q.seg[CRS_SEG_CODE];

   // Stack accesses are bound to the stack selector whatever segment is asked.
   assign oper_sel = ea_stack_i ? st_q.seg[CRS_SEG_STACK] : st_q.seg[ea_seg_i];

   // Offset is displacement plus optional base and index registers.
   assign oper_off = ea_disp_i
                   + (ea_base_en_i ? st_q.gpr[ea_base_sel_i] : 16'h0000)
                   + (ea_index_en_i ? st_q.gpr[ea_index_sel_i] : 16'h0000);

   crs_addr_form u_fetch_form (
      .selector_i(code_sel),
      .offset_i(st_q.instruction_pointer),
      .prot_mode_i(prot_mode_i),
      .xlat_base_i(code_xlat_base_i),
      .ptr_o(fetch_ptr),
      .phys_o(fetch_phys)
   );

   crs_addr_form u_oper_form (
      .selector_i(oper_sel),
      .offset_i(oper_off),
      .prot_mode_i(prot_mode_i),
      .xlat_base_i(oper_xlat_base_i),
      .ptr_o(ea_ptr),
      .phys_o(ea_phys)
   );

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   // Computes register writes, selector loads, pointer advance and outputs.
   always_comb begin
      st_d = st_q;
      st_d.seg_refused = 1'b0;
      st_d.ea_valid = ea_req_i;

      // General register write as a whole word or through a byte alias.
      if (wr_en_i) begin
         if (!wr_byte_i) begin
            st_d.gpr[wr_sel_i] = wr_data_i;
         end else if (wr_sel_i[2]) begin
            st_d.gpr[{1'b0, wr_sel_i[1:0]}][`CRS_HI_MSB:`CRS_HI_LSB] =
               wr_data_i[`CRS_LO_MSB:0];
         end else begin
            st_d.gpr[{1'b0, wr_sel_i[1:0]}][`CRS_LO_MSB:0] = wr_data_i[`CRS_LO_MSB:0];
         end
      end

      // Selector loads; the code selector refuses ordinary moves.
      if (seg_wr_en_i) begin
         unique case (seg_wr_sel_i)
            CRS_SEG_CODE: begin
               if (seg_wr_xfer_i) begin
                  st_d.seg[CRS_SEG_CODE] = seg_wr_data_i;
               end else begin
                  st_d.seg_refused = 1'b1;
               end
            end
            CRS_SEG_STACK: begin
               st_d.seg[CRS_SEG_STACK] = seg_wr_data_i;
            end
            CRS_SEG_DATA, CRS_SEG_EXTRA: begin
               st_d.seg[seg_wr_sel_i] = seg_wr_data_i;
            end
         endcase
      end

      // A control transfer load wins over a sequential advance.
      if (instruction_pointer_load_i) begin
         st_d.instruction_pointer = instruction_pointer_data_i;
      end else if (instruction_pointer_adv_i) begin
         st_d.instruction_pointer = st_q.instruction_pointer
                                  + {12'h000, instruction_pointer_len_i};
      end

      // Registered read ports show the value before any same-cycle write.
      st_d.rd_a = crs_read(st_q.gpr, rd_a_sel_i, rd_a_byte_i);
      st_d.rd_b = crs_read(st_q.gpr, rd_b_sel_i, rd_b_byte_i);

      // Fetch address is refreshed every cycle from the current state.
      st_d.fetch_ptr = fetch_ptr;
      st_d.fetch_phys = fetch_phys;

      // Operand address is held until the next request.
      if (ea_req_i) begin
         st_d.ea_ptr = ea_ptr;
         st_d.ea_phys = ea_phys;
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   // Synchronous reset gives every register a defined value.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_q <= '0;
         for (int i = 0; i < 8; i++) begin
            st_q.gpr[i] <= `CRS_GPR_RST;
         end
         st_q.seg[CRS_SEG_EXTRA] <= `CRS_SEG_RST;
         st_q.seg[CRS_SEG_STACK] <= `CRS_SEG_RST;
         st_q.seg[CRS_SEG_DATA] <= `CRS_SEG_RST;
         st_q.seg[CRS_SEG_CODE] <= `CRS_CODE_SEL_RST;
         st_q.instruction_pointer <= `CRS_INSTR_PTR_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state register.
   assign rd_a_data_o = st_q.rd_a;
   assign rd_b_data_o = st_q.rd_b;
   assign seg_refused_o = st_q.seg_refused;
   assign fetch_ptr_o = st_q.fetch_ptr;
   assign fetch_phys_o = st_q.fetch_phys;
   assign ea_ptr_o = st_q.ea_ptr;
   assign ea_phys_o = st_q.ea_phys;
   assign ea_valid_o = st_q.ea_valid;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb_main @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   // A word write is visible in full on a read port two cycles later.
   property p_word_write;
      wr_en_i && !wr_byte_i
         ##1 (rd_a_sel_i == $past(wr_sel_i) && !rd_a_byte_i && !wr_en_i)
         |=> rd_a_data_o == $past(wr_data_i, 2);
   endproperty
   a_word_write: assert property (p_word_write)
      else $error("Word write not returned by read port.");

   // A low byte write keeps the high byte.
   property p_byte_keep;
      wr_en_i && wr_byte_i && !wr_sel_i[2]
         |=> st_q.gpr[$past(wr_sel_i[1:0])][15:8] == $past(st_q.gpr[wr_sel_i[1:0]][15:8])
             && st_q.gpr[$past(wr_sel_i[1:0])][7:0] == $past(wr_data_i[7:0]);
   endproperty
   a_byte_keep: assert property (p_byte_keep)
      else $error("Low byte write disturbed the high byte.");

   // A high byte alias read returns the upper half zero-extended.
   property p_high_read;
      rd_b_byte_i && rd_b_sel_i[2]
         |=> rd_b_data_o == {8'h00, $past(st_q.gpr[rd_b_sel_i[1:0]][15:8])};
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("High byte alias read wrong.");

   // An ordinary move to the code selector is refused and changes nothing.
   property p_code_refuse;
      seg_wr_en_i && seg_wr_sel_i == CRS_SEG_CODE && !seg_wr_xfer_i
         |=> seg_refused_o && $stable(st_q.seg[CRS_SEG_CODE]);
   endproperty
   a_code_refuse: assert property (p_code_refuse)
      else $error("Code selector took an ordinary move.");

   // Stack, data and extra selectors take explicit loads.
   property p_seg_load;
      seg_wr_en_i && seg_wr_sel_i != CRS_SEG_CODE
         |=> st_q.seg[$past(seg_wr_sel_i)] == $past(seg_wr_data_i) && !seg_refused_o;
   endproperty
   a_seg_load: assert property (p_seg_load)
      else $error("Selector load lost.");

   // Fetch pointer pairs the code selector with the instruction pointer.
   property p_fetch_ptr;
      1'b1 |=> fetch_ptr_o == {$past(st_q.seg[CRS_SEG_CODE]), $past(st_q.instruction_pointer)};
   endproperty
   a_fetch_ptr: assert property (p_fetch_ptr)
      else $error("Fetch pointer not code selector and instruction pointer.");

   // Stack accesses carry the stack selector in the pointer's upper half.
   property p_stack_sel;
      ea_req_i && ea_stack_i
         |=> ea_valid_o && ea_ptr_o[31:16] == $past(st_q.seg[CRS_SEG_STACK]);
   endproperty
   a_stack_sel: assert property (p_stack_sel)
      else $error("Stack access used another selector.");

   // Real mode physical fetch address is selector times sixteen plus offset.
   property p_real_fetch;
      !prot_mode_i |=> fetch_phys_o == ({4'h0, $past(st_q.seg[CRS_SEG_CODE]), 4'h0}
                                       + {8'h00, $past(st_q.instruction_pointer)});
   endproperty
   a_real_fetch: assert property (p_real_fetch)
      else $error("Real mode fetch address wrong.");

   // Displacement-only operand offset is the displacement itself.
   property p_disp_only;
      ea_req_i && !ea_base_en_i && !ea_index_en_i |=> ea_ptr_o[15:0] == $past(ea_disp_i);
   endproperty
   a_disp_only: assert property (p_disp_only)
      else $error("Displacement offset wrong.");

endmodule : crs_reg_set
`default_nettype wire

// ==== verif/crs_decode_model.sv ====
// Purpose: Decoder-side model that streams instruction pointer advances.
// Assumes: Runs on the register set clock; loads come from the bench.
// Notes:   It mirrors the pointer so the bench can predict each fetch.
`timescale 1ns/1ps
`default_nettype none
module crs_decode_model (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic run_i,
   input wire logic ld_i,
   input wire logic [15:0] ld_data_i,
   output logic adv_o,
   output logic [3:0] len_o,
   output logic [15:0] exp_fetch_o
);
   logic [15:0] ip_m;
   // Advance every cycle while run_i is set, with lengths 1 to 15; a load wins over an advance.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         adv_o <= 1'b0;
         len_o <= 4'h1;
         ip_m <= 16'h0000;
         exp_fetch_o <= 16'h0000;
      end else begin
         adv_o <= run_i;
         if (adv_o) begin
            len_o <= (len_o == 4'hF) ? 4'h1 : len_o + 4'h1;
         end
         if (ld_i) begin
            ip_m <= ld_data_i;
         end else if (adv_o) begin
            ip_m <= ip_m + {12'h000, len_o};
         end
         exp_fetch_o <= ip_m; // The fetch output lags the pointer by one edge.
      end
   end
endmodule : crs_decode_model
`default_nettype wire

// ==== verif/crs_reg_set_bench.sv ====
// Purpose: Self-checking bench for the application register set.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes:   Register cases sit in a row table; the rest are hand-written.
`timescale 1ns/1ps
`default_nettype none
module crs_reg_set_bench;
   import crs_pkg::*;
   typedef struct packed {
      logic wb;
      logic [2:0] ws;
      logic [15:0] wd;
      logic rb;
      logic [2:0] rs;
      logic [15:0] ex;
   } crs_row_type;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] ra_sel = 3'h0, rb_sel = 3'h0, wr_sel = 3'h0, bsel = 3'h0, isel = 3'h0;
   logic ra_byte = 1'b0, rb_byte = 1'b0, wr_en = 1'b0, wr_byte = 1'b0, seg_en = 1'b0;
   logic seg_xfer = 1'b0, ip_ld = 1'b0, prot = 1'b0, ea_req = 1'b0, ea_stk = 1'b0;
   logic ben = 1'b0, ien = 1'b0, run = 1'b0, refused, evalid, adv;
   logic [15:0] wr_data = 16'h0000, seg_data = 16'h0000, ip_data = 16'h0000;
   logic [15:0] disp = 16'h0000, rd_a, rd_b, exp_ip;
   logic [23:0] cx_base = 24'h000000, ox_base = 24'h000000, fphys, ephys;
   logic [31:0] fptr, eptr;
   logic [3:0] len;
   crs_seg_type seg_sel = CRS_SEG_EXTRA, ea_seg = CRS_SEG_EXTRA;
   int err_total = 0;
   int num_checks = 0;
   crs_row_type rows [11] = '{
      '{1'b0, 3'h0, 16'h1234, 1'b0, 3'h0, 16'h1234}, '{1'b1, 3'h4, 16'hFFAB, 1'b0, 3'h0, 16'hAB34},
      '{1'b1, 3'h0, 16'h77CD, 1'b0, 3'h0, 16'hABCD}, '{1'b0, 3'h3, 16'h5A5A, 1'b1, 3'h7, 16'h005A},
      '{1'b1, 3'h3, 16'h0011, 1'b0, 3'h3, 16'h5A11}, '{1'b0, 3'h1, 16'hC001, 1'b1, 3'h1, 16'h0001},
      '{1'b0, 3'h2, 16'h8002, 1'b1, 3'h6, 16'h0080}, '{1'b0, 3'h4, 16'hF00E, 1'b0, 3'h4, 16'hF00E},
      '{1'b0, 3'h5, 16'h0BE5, 1'b0, 3'h5, 16'h0BE5}, '{1'b0, 3'h6, 16'h0006, 1'b0, 3'h6, 16'h0006},
      '{1'b0, 3'h7, 16'h7777, 1'b0, 3'h7, 16'h7777}};

   // Design under test and the decoder-side partner.
   crs_reg_set i_crs_reg_set (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .rd_a_sel_i(ra_sel),
      .rd_a_byte_i(ra_byte), .rd_b_sel_i(rb_sel), .rd_b_byte_i(rb_byte), .rd_a_data_o(rd_a),
      .rd_b_data_o(rd_b), .wr_en_i(wr_en), .wr_byte_i(wr_byte), .wr_sel_i(wr_sel),
      .wr_data_i(wr_data), .seg_wr_en_i(seg_en), .seg_wr_sel_i(seg_sel), .seg_wr_xfer_i(seg_xfer),
      .seg_wr_data_i(seg_data), .seg_refused_o(refused), .instruction_pointer_load_i(ip_ld),
      .instruction_pointer_data_i(ip_data), .instruction_pointer_adv_i(adv),
      .instruction_pointer_len_i(len), .prot_mode_i(prot), .code_xlat_base_i(cx_base),
      .oper_xlat_base_i(ox_base), .fetch_ptr_o(fptr), .fetch_phys_o(fphys), .ea_req_i(ea_req),
      .ea_stack_i(ea_stk), .ea_seg_i(ea_seg), .ea_base_en_i(ben), .ea_base_sel_i(bsel),
      .ea_index_en_i(ien), .ea_index_sel_i(isel), .ea_disp_i(disp), .ea_ptr_o(eptr),
      .ea_phys_o(ephys), .ea_valid_o(evalid));
   crs_decode_model i_crs_decode_model (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .run_i(run),
      .ld_i(ip_ld), .ld_data_i(ip_data), .adv_o(adv), .len_o(len), .exp_fetch_o(exp_ip));

   // Clock of 25 ns period.
   always #12.5 sys_clk_i = ~sys_clk_i;

   // Compares one value and counts the result.
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (exp !== got) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Loads one selector and checks the refusal pulse.
   task automatic seg_load(input crs_seg_type s, input logic x, input logic [15:0] v,
                           input logic r);
      @(posedge sys_clk_i);
      seg_en <= 1'b1;
      seg_sel <= s;
      seg_xfer <= x;
      seg_data <= v;
      @(posedge sys_clk_i);
      seg_en <= 1'b0;
      @(negedge sys_clk_i);
      check("seg_refused_o", {31'h0, r}, {31'h0, refused});
   endtask : seg_load

   // Requests one operand address and checks pointer and physical address.
   task automatic ea_run(input logic st, input crs_seg_type s, input logic be,
                         input logic [2:0] bs, input logic ie, input logic [2:0] xs,
                         input logic [15:0] d, input logic [31:0] ep, input logic [23:0] eh);
      @(posedge sys_clk_i);
      ea_req <= 1'b1;
      ea_stk <= st;
      ea_seg <= s;
      ben <= be;
      bsel <= bs;
      ien <= ie;
      isel <= xs;
      disp <= d;
      @(posedge sys_clk_i);
      ea_req <= 1'b0;
      @(negedge sys_clk_i);
      check("ea_valid_o", 32'h1, {31'h0, evalid});
      check("ea_ptr_o", ep, eptr);
      check("ea_phys_o", {8'h00, eh}, {8'h00, ephys});
   endtask : ea_run

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   // Watchdog sized well beyond the roughly 80 cycles of the tests.
   initial begin
      #100000;
      err_total++;
      summarize();
   end

   // Main sequence.
   initial begin
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(negedge sys_clk_i);
      check("fetch_ptr_o", 32'h0, fptr);
      check("rd_a_data_o", 32'h0, {16'h0, rd_a});
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge sys_clk_i);
         wr_en <= 1'b1;
         wr_byte <= rows[i].wb;
         wr_sel <= rows[i].ws;
         wr_data <= rows[i].wd;
         @(posedge sys_clk_i);
         wr_en <= 1'b0;
         ra_sel <= rows[i].rs;
         ra_byte <= rows[i].rb;
         rb_sel <= rows[i].rs;
         rb_byte <= rows[i].rb;
         @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         check("rd_a_data_o", {16'h0, rows[i].ex}, {16'h0, rd_a});
         check("rd_b_data_o", {16'h0, rows[i].ex}, {16'h0, rd_b}); // Second port.
      end
      $display("test register table done");
      seg_load(CRS_SEG_STACK, 1'b0, 16'h2000, 1'b0); // Stack load accepted.
      seg_load(CRS_SEG_DATA, 1'b0, 16'h3000, 1'b0); // Data load accepted.
      seg_load(CRS_SEG_EXTRA, 1'b0, 16'h4000, 1'b0); // Extra load accepted.
      seg_load(CRS_SEG_CODE, 1'b1, 16'h1000, 1'b0); // Transfer load accepted.
      seg_load(CRS_SEG_CODE, 1'b0, 16'hDEAD, 1'b1); // Plain load refused.
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("fetch_ptr_o", {16'h1000, 16'h0}, {fptr[31:16], 16'h0}); // Code kept.
      $display("test selectors done");
      ea_run(1'b0, CRS_SEG_DATA, 1'b1, 3'h3, 1'b1, 3'h6, 16'h0010,
             32'h30005A27, 24'h035A27);
      ea_run(1'b0, CRS_SEG_EXTRA, 1'b0, 3'h0, 1'b1, 3'h7, 16'hFFFF,
             32'h40007776, 24'h047776);
      ea_run(1'b1, CRS_SEG_EXTRA, 1'b1, 3'h5, 1'b0, 3'h0, 16'h0004,
             32'h20000BE9, 24'h020BE9);
      @(posedge sys_clk_i);
      prot <= 1'b1;
      ox_base <= 24'h123400;
      ea_run(1'b0, CRS_SEG_DATA, 1'b1, 3'h4, 1'b0, 3'h0, 16'h0002,
             32'h3000F010, 24'h132410);
      ea_run(1'b0, CRS_SEG_EXTRA, 1'b0, 3'h0, 1'b0, 3'h0, 16'h8000,
             32'h40008000, 24'h12B400);
      @(posedge sys_clk_i);
      prot <= 1'b0;
      run <= 1'b1;
      $display("test operand address done");
      for (int i = 0; i < 14; i++) begin
         @(posedge sys_clk_i);
         ip_ld <= (i == 5);
         ip_data <= 16'hFFF8;
         @(negedge sys_clk_i);
         check("fetch_ptr_o", {16'h1000, exp_ip}, fptr); // Fetch pointer.
         check("fetch_phys_o", {8'h0, 24'h010000 + {8'h0, exp_ip}}, {8'h0, fphys});
      end
      @(posedge sys_clk_i);
      run <= 1'b0;
      prot <= 1'b1;
      cx_base <= 24'hABC000;
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("fetch_phys_o", {8'h0, 24'hABC000 + {8'h0, exp_ip}}, {8'h0, fphys});
      $display("test fetch done");
      @(posedge sys_clk_i);
      srst_i <= 1'b1;
      ra_sel <= 3'h0;
      ra_byte <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      // One edge after release the read and fetch pointer outputs show the cleared state; fetch_phys_o shows the code translation base.
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("rd_a_data_o", 32'h0, {16'h0, rd_a});
      check("fetch_ptr_o", 32'h0, fptr);
      check("fetch_phys_o", {8'h0, 24'hABC000}, {8'h0, fphys});
      $display("test second reset done");
      summarize();
   end
endmodule : crs_reg_set_bench
`default_nettype wire
